// ==== include/fpeps_pkg.sv ====
package fpeps_pkg;

    // bus clock
    localparam int CLK_MHZ = 200;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PROT = 8'h04;
    localparam logic [7:0] REG_AWR = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_TIM0 = 8'h10;
    localparam logic [7:0] REG_TIM1 = 8'h14;
    localparam logic [7:0] REG_START = 8'h18;

    // control bit positions
    localparam int CB_PGM = 0;
    localparam int CB_ERASE = 1;
    localparam int CB_MASS = 2;
    localparam int CB_HIGH_VOLTAGE_ENABLE = 3;

    // status bit positions, write one to clear
    localparam int SB_SEQ = 0;
    localparam int SB_PROT = 1;
    localparam int SB_ROW = 2;
    localparam int SB_TPROG = 3;
    localparam int SB_SUSP = 4;
    localparam int SB_PBER = 5;
    localparam int STAT_W = 6;
    localparam int STAT_STATE_LSB = 8;

    // array write register fields
    localparam int AWR_DATA_LSB = 0;
    localparam int AWR_ADDR_LSB = 8;

    // array geometry
    localparam logic [7:0] PROT_OPEN = 8'hFF;
    localparam logic [15:0] PROT_BYTE_ADDR = 16'hFF80;
    localparam int PAGE_LSB = 7;
    localparam int ROW_LSB = 6;

    // phase times in ns: least times round up, longest rounds down
    localparam int NVS_NS = 10000;
    localparam int PGS_NS = 5000;
    localparam int PROG_MAX_NS = 20000;
    localparam int NVH_NS = 5000;
    localparam logic [15:0] NVS_CYC = 16'((NVS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] PGS_CYC = 16'((PGS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] PROG_CYC = 16'((PROG_MAX_NS * CLK_MHZ) / 1000);
    localparam logic [15:0] NVH_CYC = 16'((NVH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [31:0] TIM0_RST = {PGS_CYC, NVS_CYC};
    localparam logic [31:0] TIM1_RST = {NVH_CYC, PROG_CYC};

    typedef enum {
        S_IDLE,
        S_SEL,
        S_READ,
        S_ARMED,
        S_HV,
        S_STBY
    } fpeps_state_type;

    typedef struct packed {
        logic standby;
        logic hv;
        logic erase;
        logic mass;
        logic prog;
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } fpeps_arr_type;

endpackage

// ==== rtl/fpeps_sync2.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpeps_sync2 (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // asynchronous levels in, synchronised out
    input wire logic [1:0] d,
    output logic [1:0] q
);
    import fpeps_pkg::*;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= d[i];
                    sync_q <= meta_q;
                end
            end
            assign q[i] = sync_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== rtl/fpeps_prot_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpeps_prot_chk (
    // protect byte and target address
    input wire logic [7:0] prot_byte,
    input wire logic [15:0] addr,
    // result
    output logic [15:0] start_addr,
    output logic hit
);
    import fpeps_pkg::*;

    always_comb begin
        start_addr = {1'b1, prot_byte, 7'h00}; // [RL26]
        // all ones opens everything, all zeros starts at the array base
        hit = (prot_byte != PROT_OPEN) && (addr >= start_addr); // [RL1] [RL4]
    end
endmodule
`default_nettype wire

// ==== rtl/fpeps_flash_seq.sv ====
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RL1: protection runs from start address to top
// RL2: no high voltage on protected target
// RL3: software reads protect byte before high voltage
// RL4: zeros protect all, ones protect none
// RL5: erasing vector page also erases protect byte
// RL6: whole erase: select, read protect, arm write
// RL7: whole erase timing order kept by software
// RL8: protected arming write means no erase
// RL9: page erase clears one aligned 128-byte page
// RL10: page erase finish order kept by software
// RL11: never run from the array being changed
// RL12: no array access during a sequence
// RL13: interrupts best kept off during operations
// RL14: program within one 64-byte row only
// RL15: erase a row before programming it
// RL16: program select latches address and data
// RL17: byte writes then unwind in order
// RL18: cumulative high voltage per row bounded
// RL19: byte write interval bounded by maximum
// RL20: only array addresses for row or byte
// RL21: wait mode suspends operation into standby
// RL22: stop mode suspends operation into standby
// RL23: standby drives all array controls inactive
// RL24: program and erase selects are interlocked
// RL25: high voltage only after proper sequence
// RL26: protect byte gives address bits 14 to 7
// RL27: whole-array select picks mass or page
// RL28: phase durations held as cycle counts
module fpeps_flash_seq (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // low power requests
    input wire logic wait_mode,
    input wire logic stop_mode,
    // flash array
    input wire logic [7:0] prot_byte,
    output fpeps_pkg::fpeps_arr_type arr_ctl
);
    import fpeps_pkg::*;
    fpeps_state_type state_q;
    logic pgm_q, erase_q, mass_q, high_voltage_enable_q, sel_prev_q, byte_seen_q;
    logic [15:0] cnt_q;
    logic [15:0] lat_addr_q;
    logic [7:0] lat_data_q;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] stat_set;
    logic [31:0] tim0_q, tim1_q, prdata_q, rd_mux;
    logic pready_q, pslverr_q;
    fpeps_arr_type arr_q;
    logic [1:0] lp_s;
    logic lp, setup, acc, unmapped, sel, op_active;
    logic wr_ctrl, wr_arr, wr_stat, wr_t0, wr_t1, rd_prot;
    logic pw_pgm, pw_erase, pw_high_voltage_enable, ilock_bad, hv_ok, hv_try;
    logic arm_ok, row_ok, byte_ok, byte_bad, cnt_clr, hold_bad;
    logic [15:0] wr_addr, start_addr, nvs_cyc, pgs_cyc, prog_cyc, nvh_cyc;
    logic hit, prot_hit;
    fpeps_sync2 u_lp_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .d({stop_mode, wait_mode}),
        .q(lp_s)
    );
    fpeps_prot_chk u_prot (
        .prot_byte(prot_byte),
        .addr(lat_addr_q),
        .start_addr(start_addr),
        .hit(hit)
    );
    // bus decode
    assign setup = psel && !penable;
    assign acc = psel && penable && pready_q;
    assign wr_ctrl = acc && pwrite && paddr == REG_CTRL;
    assign wr_arr = acc && pwrite && paddr == REG_AWR;
    assign wr_stat = acc && pwrite && paddr == REG_STAT;
    assign wr_t0 = acc && pwrite && paddr == REG_TIM0;
    assign wr_t1 = acc && pwrite && paddr == REG_TIM1;
    assign rd_prot = acc && !pwrite && paddr == REG_PROT;
    assign wr_addr = pwdata[AWR_ADDR_LSB +: 16];
    assign pw_pgm = pwdata[CB_PGM];
    assign pw_erase = pwdata[CB_ERASE];
    assign pw_high_voltage_enable = pwdata[CB_HIGH_VOLTAGE_ENABLE];
    assign nvs_cyc = tim0_q[15:0];
    assign pgs_cyc = tim0_q[31:16];
    assign prog_cyc = tim1_q[15:0];
    assign nvh_cyc = tim1_q[31:16];
    assign lp = lp_s[0] || lp_s[1];
    assign sel = pgm_q || erase_q;
    assign op_active = state_q == S_ARMED || state_q == S_HV;
    assign prot_hit = hit || (erase_q && mass_q && prot_byte != PROT_OPEN);
    // a select may not be set while the other one is, nor both at once
    assign ilock_bad = (pw_pgm && pw_erase) || (pw_pgm && erase_q)
        || (pw_erase && pgm_q); // [RL24]
    assign hv_try = wr_ctrl && pw_high_voltage_enable && !high_voltage_enable_q;
    assign hv_ok = state_q == S_ARMED && sel && (pw_pgm || pw_erase)
        && !ilock_bad && cnt_q >= nvs_cyc && !prot_hit; // [RL2] [RL8] [RL25]
    // arming write only after the protect byte has been read
    assign arm_ok = state_q == S_READ && wr_arr && wr_addr[15]; // [RL3]
    assign row_ok = wr_addr[15:ROW_LSB] == lat_addr_q[15:ROW_LSB];
    assign byte_ok = state_q == S_HV && pgm_q && high_voltage_enable_q && wr_arr && row_ok
        && (byte_seen_q || cnt_q >= pgs_cyc); // [RL14] [RL16]
    assign byte_bad = state_q == S_HV && pgm_q && wr_arr && !row_ok;
    assign hold_bad = state_q == S_HV && wr_ctrl && !pw_high_voltage_enable
        && (sel || cnt_q < nvh_cyc);
    assign cnt_clr = arm_ok || (state_q == S_ARMED && high_voltage_enable_q) || byte_ok
        || (state_q == S_HV && sel_prev_q && !sel);
    always_comb begin
        stat_set = '0;
        stat_set[SB_SEQ] = (wr_ctrl && ilock_bad)
            || (hv_try && !hv_ok && !prot_hit) || hold_bad
            || (wr_arr && (state_q == S_SEL
            || (state_q == S_READ && !wr_addr[15])));
        stat_set[SB_PROT] = hv_try && state_q == S_ARMED && prot_hit; // [RL2]
        stat_set[SB_ROW] = byte_bad; // [RL14]
        stat_set[SB_TPROG] = state_q == S_HV && pgm_q && byte_seen_q
            && cnt_q > prog_cyc; // [RL19] [RL28]
        stat_set[SB_SUSP] = op_active && lp;
        // the protect byte shares the vector page and goes with it
        stat_set[SB_PBER] = hv_try && hv_ok && erase_q && (mass_q
        || lat_addr_q[15:PAGE_LSB] == PROT_BYTE_ADDR[15:PAGE_LSB]); // [RL5]
    end
    // control bits
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pgm_q <= 1'b0;
            erase_q <= 1'b0;
            mass_q <= 1'b0;
            high_voltage_enable_q <= 1'b0;
        end else if (op_active && lp) begin
            pgm_q <= 1'b0; // [RL21] [RL22]
            erase_q <= 1'b0;
            mass_q <= 1'b0;
            high_voltage_enable_q <= 1'b0;
        end else if (wr_ctrl && state_q != S_STBY) begin
            if (!ilock_bad) begin
                pgm_q <= pw_pgm; // [RL24]
                erase_q <= pw_erase;
            end
            if (!high_voltage_enable_q) begin
                mass_q <= pwdata[CB_MASS]; // [RL27]
            end
            if (!pw_high_voltage_enable) begin
                high_voltage_enable_q <= 1'b0;
            end else if (hv_ok) begin
                high_voltage_enable_q <= 1'b1; // [RL25]
            end
        end
    end
    // sequence tracking
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (sel) begin
                        state_q <= S_SEL;
                    end
                end
                S_SEL: begin
                    if (!sel) begin
                        state_q <= S_IDLE;
                    end else if (rd_prot) begin
                        state_q <= S_READ; // [RL3]
                    end
                end
                S_READ: begin
                    if (!sel) begin
                        state_q <= S_IDLE;
                    end else if (arm_ok) begin
                        state_q <= S_ARMED; // [RL6] [RL9] [RL16]
                    end
                end
                S_ARMED: begin
                    if (lp) begin
                        state_q <= S_STBY; // [RL21] [RL22]
                    end else if (!sel) begin
                        state_q <= S_IDLE;
                    end else if (high_voltage_enable_q) begin
                        state_q <= S_HV;
                    end
                end
                S_HV: begin
                    if (lp) begin
                        state_q <= S_STBY; // [RL21] [RL22]
                    end else if (!high_voltage_enable_q) begin
                        state_q <= S_IDLE;
                    end
                end
                S_STBY: begin
                    if (!lp) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
    // phase counter, saturating so a long wait never wraps to short
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (cnt_clr) begin
            cnt_q <= '0; // [RL28]
        end else if (cnt_q != 16'hFFFF) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sel_prev_q <= 1'b0;
            byte_seen_q <= 1'b0;
        end else begin
            sel_prev_q <= sel;
            if (state_q != S_HV) begin
                byte_seen_q <= 1'b0;
            end else if (byte_ok) begin
                byte_seen_q <= 1'b1;
            end
        end
    end
    // latched address and data
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lat_addr_q <= '0;
            lat_data_q <= '0;
        end else if (arm_ok || byte_ok) begin
            lat_addr_q <= wr_addr; // [RL16]
            lat_data_q <= pwdata[AWR_DATA_LSB +: 8];
        end
    end
    // sticky status, a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= '0;
        end else if (wr_stat) begin
            stat_q <= (stat_q & ~pwdata[STAT_W-1:0]) | stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end
    // phase durations
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tim0_q <= TIM0_RST;
            tim1_q <= TIM1_RST;
        end else begin
            if (wr_t0) begin
                tim0_q <= pwdata; // [RL28]
            end
            if (wr_t1) begin
                tim1_q <= pwdata;
            end
        end
    end
    // array controls
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            arr_q <= '0;
        end else if (state_q == S_STBY || (op_active && lp)) begin
            arr_q <= '0; // [RL23]
            arr_q.standby <= 1'b1;
        end else begin
            arr_q.standby <= 1'b0;
            arr_q.hv <= high_voltage_enable_q;
            arr_q.erase <= erase_q;
            arr_q.mass <= erase_q && mass_q; // [RL27]
            arr_q.prog <= pgm_q;
            arr_q.wr <= byte_ok; // [RL14]
            arr_q.data <= byte_ok ? pwdata[AWR_DATA_LSB +: 8] : lat_data_q;
            if (byte_ok) begin
                arr_q.addr <= wr_addr;
            end else if (erase_q && !mass_q) begin
                arr_q.addr <= {lat_addr_q[15:PAGE_LSB], 7'h00}; // [RL9]
            end else begin
                arr_q.addr <= lat_addr_q;
            end
        end
    end
    // read mux, sampled in the setup phase
    always_comb begin
        rd_mux = '0;
        unmapped = 1'b0;
        case (paddr)
            REG_CTRL: begin
                rd_mux[CB_PGM] = pgm_q;
                rd_mux[CB_ERASE] = erase_q;
                rd_mux[CB_MASS] = mass_q;
                rd_mux[CB_HIGH_VOLTAGE_ENABLE] = high_voltage_enable_q;
            end
            REG_PROT: rd_mux[7:0] = prot_byte;
            REG_AWR: rd_mux[23:0] = {lat_addr_q, lat_data_q};
            REG_STAT: begin
                rd_mux[STAT_W-1:0] = stat_q;
                rd_mux[STAT_STATE_LSB +: 3] = 3'(state_q);
            end
            REG_TIM0: rd_mux = tim0_q;
            REG_TIM1: rd_mux = tim1_q;
            REG_START: rd_mux[15:0] = start_addr;
            default: unmapped = 1'b1;
        endcase
    end
    // no wait state, yet every answer leaves a flip-flop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && unmapped;
            if (setup && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign arr_ctl = arr_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    hv_not_protected_a: assert property ( // [RL2]
        $rose(high_voltage_enable_q) |-> !$past(prot_hit))
        else $error("high voltage set on protected target");
    sel_interlock_a: assert property ( // [RL24]
        !(pgm_q && erase_q) && !(arr_q.prog && arr_q.erase))
        else $error("program and erase selected together");
    hv_sequence_a: assert property ( // [RL25]
        $rose(high_voltage_enable_q) |-> $past(state_q) == S_ARMED
            ##1 (state_q == S_HV || state_q == S_STBY))
        else $error("high voltage outside armed state");
    nvs_wait_a: assert property ( // [RL28]
        $rose(high_voltage_enable_q) |-> $past(cnt_q) >= $past(nvs_cyc))
        else $error("high voltage before setup time");
    lp_suspend_a: assert property ( // [RL21]
        lp && op_active |=> state_q == S_STBY && !high_voltage_enable_q && !sel)
        else $error("low power did not suspend operation");
    stby_quiet_a: assert property ( // [RL23]
        state_q == S_STBY |=> arr_q.standby && !arr_q.hv && !arr_q.wr
            && !arr_q.erase && !arr_q.prog)
        else $error("array control active in standby");
    row_refuse_a: assert property ( // [RL14]
        byte_bad |=> !arr_q.wr && stat_q[SB_ROW])
        else $error("cross row write reached the array");
    page_align_a: assert property ( // [RL9]
        arr_q.erase && !arr_q.mass |-> arr_q.addr[6:0] == 7'h00)
        else $error("page erase address not aligned");
endmodule
`default_nettype wire

// ==== testbench/fpeps_array_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpeps_array_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // array controls from the sequencer
    input wire fpeps_pkg::fpeps_arr_type arr_ctl,
    // bench preset of the stored protect byte
    input wire logic load,
    input wire logic [7:0] load_val,
    // stored protect byte and write log
    output logic [7:0] prot_byte,
    output logic [15:0] wr_cnt,
    output logic [23:0] last_wr
);
    import fpeps_pkg::*;
    logic [7:0] prot_q;
    assign prot_byte = prot_q;
    // erase restores ones, programming can only clear bits
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prot_q <= PROT_OPEN;
        end else if (load) begin
            prot_q <= load_val;
        end else if (arr_ctl.hv && arr_ctl.erase && (arr_ctl.mass
                || arr_ctl.addr[15:7] == PROT_BYTE_ADDR[15:7])) begin
            prot_q <= PROT_OPEN;
        end else if (arr_ctl.wr && arr_ctl.addr == PROT_BYTE_ADDR) begin
            prot_q <= prot_q & arr_ctl.data;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_cnt <= 16'h0000;
            last_wr <= 24'h000000;
        end else if (arr_ctl.wr) begin
            wr_cnt <= wr_cnt + 16'h0001;
            last_wr <= {arr_ctl.addr, arr_ctl.data};
        end
    end
endmodule
`default_nettype wire

// ==== testbench/fpeps_flash_seq_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpeps_flash_seq_tb;
    import fpeps_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic [7:0] prot_byte;
    fpeps_arr_type arr_ctl;
    logic load = 1'b0;
    logic [7:0] load_val = 8'hFF;
    logic [15:0] wr_cnt;
    logic [23:0] last_wr;
    logic [31:0] rdat;
    logic rerr;
    int failures = 0;
    int cmp_count = 0;
    logic [3:0] sel_t [6] = '{4'h2, 4'h2, 4'h6, 4'h6, 4'h2, 4'h6};
    logic [15:0] adr_t [6] = '{16'h8123, 16'h9000, 16'h9000, 16'h8000,
                               16'hFFA0, 16'h8000};
    logic [7:0] pro_t [6] = '{8'hFF, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h08};
    logic [5:0] lvl_t [6] = '{6'h18, 6'h08, 6'h0C, 6'h1C, 6'h18, 6'h0C};
    logic [5:0] sta_t [6] = '{6'h00, 6'h02, 6'h02, 6'h20, 6'h20, 6'h02};
    logic [7:0] st_t [3] = '{8'h00, 8'h08, 8'hFE};

    always #2.5 sys_clk = ~sys_clk;

    fpeps_flash_seq dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .prot_byte(prot_byte), .arr_ctl(arr_ctl)
    );
    fpeps_array_model arr_u (
        .sys_clk(sys_clk), .rstn(rstn), .arr_ctl(arr_ctl), .load(load),
        .load_val(load_val), .prot_byte(prot_byte), .wr_cnt(wr_cnt),
        .last_wr(last_wr)
    );

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    function automatic logic [5:0] lv();
        return {arr_ctl.standby, arr_ctl.hv, arr_ctl.erase, arr_ctl.mass,
                arr_ctl.prog, arr_ctl.wr};
    endfunction

    task automatic setp(input logic [7:0] v);
        load_val <= v;
        load <= 1'b1;
        @(posedge sys_clk);
        load <= 1'b0;
        @(posedge sys_clk);
    endtask

    // select, protect read, arming write, setup wait, high voltage
    task automatic seq_op(input logic [3:0] sel, input logic [15:0] a,
                          input logic [7:0] p);
        setp(p);
        wr(REG_CTRL, {28'h0, sel});
        rd(REG_PROT);
        wr(REG_AWR, {8'h00, a, 8'h00});
        cyc(8);
        wr(REG_CTRL, {28'h0, sel | 4'h8});
        cyc(2);
    endtask

    task automatic unwind;
        wr(REG_CTRL, 32'h8);
        cyc(8);
        wr(REG_CTRL, 32'h0);
        cyc(2);
    endtask

    task automatic t_regs;
        rd(REG_TIM0);
        chk("tim0", rdat, TIM0_RST);
        rd(REG_TIM1);
        chk("tim1", rdat, TIM1_RST);
        rd(8'h40);
        chk("unmapped", {31'h0, rerr}, 32'h1);
        wr(REG_TIM0, 32'h0004_0004);
        wr(REG_TIM1, 32'h0004_0028);
        rd(REG_TIM1);
        chk("tim1 new", rdat, 32'h0004_0028);
        $display("done registers");
    endtask

    task automatic t_start;
        for (int i = 0; i < 3; i++) begin
            setp(st_t[i]);
            rd(REG_START);
            chk("start", rdat, {16'h0, 1'b1, st_t[i], 7'h0});
            rd(REG_PROT);
            chk("prot", rdat, {24'h0, st_t[i]});
        end
        $display("done start address");
    endtask

    task automatic t_erase;
        for (int i = 0; i < 6; i++) begin
            seq_op(sel_t[i], adr_t[i], pro_t[i]);
            chk("erase lv", lv(), lvl_t[i]);
            if (sel_t[i] == 4'h2 && lvl_t[i][4]) begin
                chk("page", arr_ctl.addr, adr_t[i] & 16'hFF80);
            end
            unwind;
            rd(REG_STAT);
            chk("erase st", rdat[5:0] & 6'h22, sta_t[i]);
            wr(REG_STAT, 32'h3F);
        end
        $display("done erase");
    endtask

    task automatic byte_write_time;
        logic [15:0] n0;
        seq_op(4'h1, 16'h8040, 8'hFF);
        chk("prog lv", lv(), 6'h12);
        cyc(6);
        n0 = wr_cnt;
        wr(REG_AWR, 32'h0080_415A);
        wr(REG_AWR, 32'h0080_8033);
        cyc(2);
        chk("bytes", wr_cnt, n0 + 16'h0001);
        chk("byte", last_wr, 24'h80415A);
        cyc(50);
        rd(REG_STAT);
        chk("row late", rdat[5:0] & 6'h0C, 6'h0C);
        unwind;
        wr(REG_STAT, 32'h3F);
        $display("done program");
    endtask

    task automatic t_lock;
        wr(REG_CTRL, 32'h3);
        cyc(2);
        chk("both sel", lv(), 6'h00);
        wr(REG_CTRL, 32'h1);
        wr(REG_CTRL, 32'h9);
        cyc(2);
        chk("early hv", lv(), 6'h02);
        rd(REG_STAT);
        chk("seq err", rdat[0], 1'b1);
        wr(REG_CTRL, 32'h0);
        wr(REG_STAT, 32'h3F);
        $display("done interlock");
    endtask

    task automatic t_lowp;
        for (int m = 0; m < 2; m++) begin
            {stop_mode, wait_mode} <= 2'(m + 1);
            cyc(6);
            chk("idle lp", lv(), 6'h00);
            {stop_mode, wait_mode} <= 2'h0;
            cyc(6);
            seq_op(4'h2, 16'h8200, 8'hFF);
            {stop_mode, wait_mode} <= 2'(m + 1);
            cyc(6);
            chk("stby lv", lv(), 6'h20);
            rd(REG_STAT);
            chk("stby st", {rdat[10:8], rdat[4]}, 4'hB);
            {stop_mode, wait_mode} <= 2'h0;
            cyc(6);
            rd(REG_STAT);
            chk("back idle", rdat[10:8], 3'h0);
            wr(REG_STAT, 32'h3F);
        end
        $display("done low power");
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        cyc(2);
        t_regs;
        t_start;
        t_erase;
        byte_write_time;
        t_lock;
        t_lowp;
        close_out;
    end

    // about thirty-five times the length of the whole sequence
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        close_out;
    end
endmodule
`default_nettype wire
